// ### hw/grcmd_defs.vh
`ifndef GRCMD_DEFS_VH
`define GRCMD_DEFS_VH

`define GRCMD_OP_PIN_QUERY  8'h51
`define GRCMD_OP_SETTINGS   8'h60
`define GRCMD_STATUS_OK     8'h00
`define GRCMD_LEVEL_UNUSED  8'hEE
`define GRCMD_DIR_UNUSED    8'hEF
`define GRCMD_DIR_OUTPUT    8'h00
`define GRCMD_DIR_INPUT     8'h01
`define GRCMD_FILL_BYTE     8'h00
`define GRCMD_REPORT_LEN    7'h40
`define GRCMD_LAST_IDX      6'h3F
`define GRCMD_LOAD_BIT      7
`define GRCMD_IDX_DIVIDER   6'h02
`define GRCMD_IDX_REFERENCE 6'h03
`define GRCMD_IDX_DAC_CODE  6'h04
`define GRCMD_DIV_FIELD     2:0
`define GRCMD_DUTY_FIELD    4:3
`define GRCMD_VRM_FIELD     2:1
`define GRCMD_SRC_BIT       0
`define GRCMD_DAC_FIELD     4:0
`define GRCMD_CLK_DIV_RST   5'h00
`define GRCMD_DAC_REF_RST   3'h0
`define GRCMD_DAC_CODE_RST  5'h00

`endif

// ### hw/grcmd_pin_report.v
`timescale 1ns/100ps
`include "grcmd_defs.vh"

module grcmd_pin_report (
    input  wire       isGpio,
    input  wire       isInput,
    input  wire       level,
    output wire [7:0] levelByte,
    output wire [7:0] dirByte
);

    assign levelByte = isGpio ? {7'h00, level} : `GRCMD_LEVEL_UNUSED;
    assign dirByte   = !isGpio ? `GRCMD_DIR_UNUSED :
                       (isInput ? `GRCMD_DIR_INPUT : `GRCMD_DIR_OUTPUT);

endmodule

// ### hw/grcmd_top.v
`timescale 1ns/100ps
`include "grcmd_defs.vh"

module grcmd_top #(
    parameter PINS = 4
) (
    input  wire            clk,
    input  wire            rst,
    input  wire            cmdValid,
    output wire            cmdReady,
    input  wire [7:0]      cmdByte,
    input  wire            cmdLast,
    output reg             rspValid,
    input  wire            rspReady,
    output reg  [7:0]      rspByte,
    output reg             rspLast,
    input  wire [PINS-1:0] pinIsGpio,
    input  wire [PINS-1:0] pinIsInput,
    input  wire [PINS-1:0] pinLevel,
    output reg  [2:0]      clkDivValue,
    output reg  [1:0]      clkDuty,
    output reg  [1:0]      refModuleLevel,
    output reg             dacRefInternal,
    output reg  [4:0]      dacCode,
    output reg             settingsApplied
);

    // ------------------------------------------------
    // states
    // ------------------------------------------------
    localparam ST_RECV = 2'd0;
    localparam ST_SEND = 2'd1;
    localparam ST_DROP = 2'd2;

    reg  [1:0]      state;
    reg  [5:0]      rxIdx;
    reg  [5:0]      txIdx;
    reg  [7:0]      opcode;
    reg  [PINS-1:0] pinLevelMeta;
    reg  [PINS-1:0] pinLevelSync;
    reg  [PINS-1:0] pinGpioMeta;
    reg  [PINS-1:0] pinGpioSync;
    reg  [PINS-1:0] pinDirMeta;
    reg  [PINS-1:0] pinDirSync;
    reg  [PINS-1:0] snapLevel;
    reg  [PINS-1:0] snapGpio;
    reg  [PINS-1:0] snapDir;
    reg  [7:0]      next_rspByte;

    wire [8*PINS-1:0] levelBytes;
    wire [8*PINS-1:0] dirBytes;
    wire              rxFire;
    wire              txFire;
    wire              settingsByte;
    wire              loadDivider;
    wire              loadReference;
    wire              loadDacCode;
    wire              reportEnd;
    wire [7:0]        endOpcode;

    // ------------------------------------------------
    // command decode
    // ------------------------------------------------
    assign cmdReady = (state == ST_RECV);
    assign rxFire   = cmdValid && cmdReady;
    assign txFire   = rspValid && rspReady;
    // byte 1 and reserved bits never reach a setting
    assign settingsByte  = rxFire && opcode == `GRCMD_OP_SETTINGS && rxIdx != 6'h00;
    assign loadDivider   = settingsByte && rxIdx == `GRCMD_IDX_DIVIDER &&
                           cmdByte[`GRCMD_LOAD_BIT];
    assign loadReference = settingsByte && rxIdx == `GRCMD_IDX_REFERENCE &&
                           cmdByte[`GRCMD_LOAD_BIT];
    assign loadDacCode   = settingsByte && rxIdx == `GRCMD_IDX_DAC_CODE &&
                           cmdByte[`GRCMD_LOAD_BIT];
    assign reportEnd     = rxFire && (cmdLast || rxIdx == `GRCMD_LAST_IDX);
    assign endOpcode     = (rxIdx == 6'h00) ? cmdByte : opcode;

    // ------------------------------------------------
    // pin level synchroniser
    // ------------------------------------------------
    // meta stage feeds only the second flop
    always @(posedge clk) begin
        if (rst) begin
            pinLevelMeta <= {PINS{1'b0}};
            pinLevelSync <= {PINS{1'b0}};
        end else begin
            pinLevelMeta <= pinLevel;
            pinLevelSync <= pinLevelMeta;
        end
    end

    // ------------------------------------------------
    // pin function synchroniser
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            pinGpioMeta <= {PINS{1'b0}};
            pinGpioSync <= {PINS{1'b0}};
        end else begin
            pinGpioMeta <= pinIsGpio;
            pinGpioSync <= pinGpioMeta;
        end
    end

    // ------------------------------------------------
    // pin direction synchroniser
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            pinDirMeta <= {PINS{1'b0}};
            pinDirSync <= {PINS{1'b0}};
        end else begin
            pinDirMeta <= pinIsInput;
            pinDirSync <= pinDirMeta;
        end
    end

    // ------------------------------------------------
    // per-pin reply bytes
    // ------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PINS; p = p + 1) begin : gPin
            grcmd_pin_report uReport (
                .isGpio    (snapGpio[p]),
                .isInput   (snapDir[p]),
                .level     (snapLevel[p]),
                .levelByte (levelBytes[8*p+7:8*p]),
                .dirByte   (dirBytes[8*p+7:8*p])
            );
        end
    endgenerate

    // ------------------------------------------------
    // reply byte select
    // ------------------------------------------------
    always @* begin
        next_rspByte = `GRCMD_FILL_BYTE;
        if (txIdx == 6'h00) begin
            next_rspByte = `GRCMD_OP_PIN_QUERY;
        end else if (txIdx == 6'h01) begin
            next_rspByte = `GRCMD_STATUS_OK;
        end else if (txIdx >= 6'h02 && txIdx < 6'h02 + 2 * PINS) begin
            // level byte first, direction second
            if (txIdx[0] == 1'b0) begin
                next_rspByte = levelBytes[8*(txIdx[5:1]-1) +: 8];
            end else begin
                next_rspByte = dirBytes[8*(txIdx[5:1]-1) +: 8];
            end
        end
    end

    // ------------------------------------------------
    // command byte counter
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rxIdx <= 6'h00;
        end else if (reportEnd) begin
            rxIdx <= 6'h00;
        end else if (rxFire) begin
            rxIdx <= rxIdx + 6'h01;
        end
    end

    // ------------------------------------------------
    // command code latch
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            opcode <= 8'h00;
        end else if (rxFire && rxIdx == 6'h00) begin
            opcode <= cmdByte;
        end
    end

    // ------------------------------------------------
    // pin snapshot
    // ------------------------------------------------
    // frozen so one reply never mixes two samples
    always @(posedge clk) begin
        if (rst) begin
            snapLevel <= {PINS{1'b0}};
            snapGpio  <= {PINS{1'b0}};
            snapDir   <= {PINS{1'b0}};
        end else if (reportEnd && endOpcode == `GRCMD_OP_PIN_QUERY) begin
            snapLevel <= pinLevelSync;
            snapGpio  <= pinGpioSync;
            snapDir   <= pinDirSync;
        end
    end

    // ------------------------------------------------
    // clock output divider and duty
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            // volatile copy, back to defaults only at reset
            {clkDuty, clkDivValue} <= `GRCMD_CLK_DIV_RST;
        end else if (loadDivider) begin
            clkDivValue <= cmdByte[`GRCMD_DIV_FIELD];
            clkDuty     <= cmdByte[`GRCMD_DUTY_FIELD];
        end
    end

    // ------------------------------------------------
    // dac reference selection
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            {refModuleLevel, dacRefInternal} <= `GRCMD_DAC_REF_RST;
        end else if (loadReference) begin
            refModuleLevel <= cmdByte[`GRCMD_VRM_FIELD];
            dacRefInternal <= cmdByte[`GRCMD_SRC_BIT];
        end
    end

    // ------------------------------------------------
    // dac output code
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            dacCode <= `GRCMD_DAC_CODE_RST;
        end else if (loadDacCode) begin
            // bits 6..5 lie outside the field and are dropped
            dacCode <= cmdByte[`GRCMD_DAC_FIELD];
        end
    end

    // ------------------------------------------------
    // settings report done pulse
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            settingsApplied <= 1'b0;
        end else begin
            settingsApplied <= reportEnd && endOpcode == `GRCMD_OP_SETTINGS;
        end
    end

    // ------------------------------------------------
    // reply byte counter
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            txIdx <= 6'h00;
        end else if (txFire) begin
            // wraps to zero after byte 63, ready for the next reply
            txIdx <= txIdx + 6'h01;
        end
    end

    // ------------------------------------------------
    // reply byte register
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rspByte <= 8'h00;
            rspLast <= 1'b0;
        end else if (state == ST_DROP) begin
            rspByte <= next_rspByte;
            rspLast <= (txIdx == `GRCMD_LAST_IDX);
        end else if (txFire) begin
            rspLast <= 1'b0;
        end
    end

    // ------------------------------------------------
    // receive and reply sequencing
    // ------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            state    <= ST_RECV;
            rspValid <= 1'b0;
        end else begin
            case (state)
                ST_RECV: begin
                    // a pin query turns the block round
                    if (reportEnd && endOpcode == `GRCMD_OP_PIN_QUERY) begin
                        state <= ST_DROP;
                    end
                end
                ST_DROP: begin
                    // one cycle per byte to register the reply byte at txIdx before it is offered
                    rspValid <= 1'b1;
                    state    <= ST_SEND;
                end
                ST_SEND: begin
                    if (txFire) begin
                        rspValid <= 1'b0;
                        if (txIdx == `GRCMD_LAST_IDX) begin
                            state <= ST_RECV;
                        end else begin
                            state <= ST_DROP;
                        end
                    end
                end
                default: begin
                    state <= ST_RECV;
                end
            endcase
        end
    end

endmodule

// ### sim/grcmd_host.sv
`timescale 1ns/100ps
module grcmd_host (
    input  wire        clk,
    input  wire        cmdReady,
    output logic       cmdValid,
    output logic [7:0] cmdByte,
    output logic       cmdLast,
    input  wire        rspValid,
    output logic       rspReady,
    input  wire  [7:0] rspByte
);
    // ----
    // host side of the report exchange
    // ----
    logic [7:0] tx [0:63];
    logic [7:0] rx [0:63];
    initial begin
        cmdValid = 1'b0;
        cmdByte = 8'h00;
        cmdLast = 1'b0;
        rspReady = 1'b0;
    end
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            cmdValid = 1'b1;
            cmdByte = tx[i];
            cmdLast = (i == n - 1);
            while (!cmdReady) @(posedge clk) #1;
            @(posedge clk) #1;
        end
        cmdValid = 1'b0;
        cmdLast = 1'b0;
        cmdByte = ~cmdByte;
    endtask
    task automatic recv(input int slow);
        for (int i = 0; i < 64; i++) begin
            while (!rspValid) @(posedge clk) #1;
            if (slow != 0) @(posedge clk) #1;
            rx[i] = rspByte;
            rspReady = 1'b1;
            @(posedge clk) #1;
            rspReady = 1'b0;
        end
    endtask
endmodule

// ### sim/grcmd_top_chk.sv
`timescale 1ns/100ps
module grcmd_chk (
    input logic       clk,
    input logic       rst,
    input logic       cmdValid,
    input logic       cmdReady,
    input logic [7:0] cmdByte,
    input logic       cmdLast,
    input logic       rspValid,
    input logic       rspReady,
    input logic [7:0] rspByte,
    input logic [2:0] clkDivValue,
    input logic [1:0] clkDuty,
    input logic [1:0] refModuleLevel,
    input logic       dacRefInternal,
    input logic [4:0] dacCode,
    input logic       rspLast,
    input logic       settingsApplied
);
    // ----
    // byte position tracking
    // ----
    logic [6:0] idx;
    logic [7:0] op;
    wire        take = cmdValid && cmdReady;
    wire        s2 = take && op == 8'h60 && idx == 7'h02;
    wire        s3 = take && op == 8'h60 && idx == 7'h03;
    wire        s4 = take && op == 8'h60 && idx == 7'h04;
    wire [4:0]  div = {clkDuty, clkDivValue};
    wire [2:0]  ref3 = {refModuleLevel, dacRefInternal};
    wire [12:0] setv = {div, ref3, dacCode};
    logic [5:0] rc;
    wire        endSet = take && (cmdLast || idx == 7'h3F) &&
                         (idx == 7'h00 ? cmdByte : op) == 8'h60;
    always @(posedge clk) begin
        if (rst) rc <= 6'h00;
        else if (rspValid && rspReady) rc <= rc + 6'h01;
        if (rst) idx <= 7'h00;
        else if (take) idx <= (cmdLast || idx == 7'h3F) ? 7'h00 : idx + 7'h01;
        if (take && idx == 7'h00) op <= cmdByte;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_div_load: assert property (s2 && cmdByte[7] |=> div == $past(cmdByte[4:0]))
        else $error("divider not loaded");
    a_div_keep: assert property (s2 && !cmdByte[7] |=> div == $past(div))
        else $error("divider changed without load bit");
    a_ref_load: assert property (s3 && cmdByte[7] |=> ref3 == $past(cmdByte[2:0]))
        else $error("reference not loaded");
    a_ref_keep: assert property (s3 && !cmdByte[7] |=> ref3 == $past(ref3))
        else $error("reference changed without load bit");
    a_dac_load: assert property (s4 && cmdByte[7] |=> dacCode == $past(cmdByte[4:0]))
        else $error("dac code not loaded");
    a_dac_keep: assert property (s4 && !cmdByte[7] |=> dacCode == $past(dacCode))
        else $error("dac code changed without load bit");
    a_set_quiet: assert property (!$past(rst) && !$past(take) && !$past(take, 2) |-> $stable(setv))
        else $error("settings moved with no command");
    a_reply_start: assert property (take && cmdLast && idx == 7'h00 && cmdByte == 8'h51
        |-> ##[1:3] rspValid && rspByte == 8'h51)
        else $error("pin reply did not start");
    a_reply_hold: assert property (rspValid && !rspReady |=> rspValid && $stable(rspByte))
        else $error("reply byte dropped before taken");
    a_applied_pulse: assert property (settingsApplied == $past(endSet))
        else $error("settings done pulse wrong");
    a_last_mark: assert property (rspValid |-> rspLast == (rc == 6'h3F))
        else $error("last reply byte mark wrong");
    cover property (s2 && cmdByte[7]);
    cover property (s4 && !cmdByte[7]);
    cover property (rspValid && rspReady && rspByte == 8'hEE);
endmodule
bind grcmd_top grcmd_chk u_chk (
    .clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdByte(cmdByte),
    .cmdLast(cmdLast), .rspValid(rspValid), .rspReady(rspReady), .rspByte(rspByte),
    .clkDivValue(clkDivValue), .clkDuty(clkDuty), .refModuleLevel(refModuleLevel),
    .dacRefInternal(dacRefInternal), .dacCode(dacCode), .rspLast(rspLast),
    .settingsApplied(settingsApplied)
);

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  gp = 4'h5;
    logic [3:0]  inp = 4'h3;
    logic [3:0]  lvl = 4'h9;
    wire         cmdValid, cmdReady, cmdLast, rspValid, rspReady, dacRefInternal;
    wire  [7:0]  cmdByte, rspByte;
    wire  [2:0]  clkDivValue;
    wire  [1:0]  clkDuty, refModuleLevel;
    wire  [4:0]  dacCode;
    wire  [12:0] setv = {clkDuty, clkDivValue, refModuleLevel, dacRefInternal, dacCode};
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [36:0] rows [0:4] = '{
        {8'h80, 8'h87, 8'h9F, 13'h00FF}, {8'hE9, 8'hF8, 8'hE0, 13'h0900},
        {8'h17, 8'h05, 8'h15, 13'h0900}, {8'h96, 8'h82, 8'h8A, 13'h164A},
        {8'h9F, 8'h85, 8'h00, 13'h1FAA}};
    grcmd_top u_dut (
        .clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdByte(cmdByte),
        .cmdLast(cmdLast), .rspValid(rspValid), .rspReady(rspReady), .rspByte(rspByte),
        .rspLast(), .pinIsGpio(gp), .pinIsInput(inp), .pinLevel(lvl),
        .clkDivValue(clkDivValue), .clkDuty(clkDuty), .refModuleLevel(refModuleLevel),
        .dacRefInternal(dacRefInternal), .dacCode(dacCode), .settingsApplied());
    grcmd_host u_host (
        .clk(clk), .cmdReady(cmdReady), .cmdValid(cmdValid), .cmdByte(cmdByte),
        .cmdLast(cmdLast), .rspValid(rspValid), .rspReady(rspReady), .rspByte(rspByte));
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic setcmd(input logic [7:0] op, b2, b3, b4);
        u_host.tx[0] = op;
        u_host.tx[1] = 8'hA5;
        u_host.tx[2] = b2;
        u_host.tx[3] = b3;
        u_host.tx[4] = b4;
        u_host.send(5);
        repeat (2) @(posedge clk);
        #1;
    endtask
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        for (int r = 0; r < 5; r++) begin
            setcmd(8'h60, rows[r][36:29], rows[r][28:21], rows[r][20:13]);
            chk(setv, rows[r][12:0]);
        end
        setcmd(8'h52, 8'h80, 8'h80, 8'h80);
        chk(setv, 13'h1FAA);
        for (int k = 0; k < 2; k++) begin
            gp = k ? 4'hA : 4'h5;
            lvl = k ? 4'h6 : 4'h9;
            repeat (3) @(posedge clk) #1;
            u_host.tx[0] = 8'h51;
            u_host.send(1);
            u_host.recv(k);
            chk(u_host.rx[0], 13'h0051);
            chk(u_host.rx[1], 13'h0000);
            for (int p = 0; p < 4; p++) begin
                chk(u_host.rx[2 + 2 * p], gp[p] ? lvl[p] : 13'h00EE);
                chk(u_host.rx[3 + 2 * p], gp[p] ? inp[p] : 13'h00EF);
            end
        end
        rst = 1'b1;
        @(posedge clk) #1;
        rst = 1'b0;
        chk(setv, 13'h0000);
        finish_test();
    end
endmodule
